// File: inc/rcf_pkg.sv
package rcf_pkg;

  // Register byte addresses on the software port.
  localparam logic [15:0] ADDR_BOD_CTRL   = 16'h0191;
  localparam logic [15:0] ADDR_FLAGS_PRI  = 16'h0192;
  localparam logic [15:0] ADDR_FLAGS_SEC  = 16'h0193;
  localparam logic [15:0] ADDR_EVT_STATUS = 16'h0194;
  localparam logic [15:0] ADDR_EVT_MASK   = 16'h0195;

  // Field positions in the brown-out control register.
  localparam int unsigned BIT_SW_BOD_EN = 7;
  localparam int unsigned BIT_BOD_READY = 0;

  // Field positions in the primary flag register.
  localparam int unsigned BIT_BROWNOUT    = 0;
  localparam int unsigned BIT_POWER_ON    = 1;
  localparam int unsigned BIT_SOFT_RST    = 2;
  localparam int unsigned BIT_EXT_PIN     = 3;
  localparam int unsigned BIT_WATCHDOG    = 4;
  localparam int unsigned BIT_STACK_UNDER = 6;
  localparam int unsigned BIT_STACK_OVER  = 7;

  // Field position in the secondary flag register.
  localparam int unsigned BIT_MEM_FAULT = 1;

  // Flag cell indices; one cell per reset-cause flag.
  localparam int unsigned FLAG_N        = 8;
  localparam int unsigned IDX_BROWNOUT  = 0;
  localparam int unsigned IDX_POWER_ON  = 1;
  localparam int unsigned IDX_SOFT_RST  = 2;
  localparam int unsigned IDX_EXT_PIN   = 3;
  localparam int unsigned IDX_WATCHDOG  = 4;
  localparam int unsigned IDX_STK_UNDER = 5;
  localparam int unsigned IDX_STK_OVER  = 6;
  localparam int unsigned IDX_MEM_FAULT = 7;

  // Power-on values per cell index, and the value each cause drives.
  localparam logic [7:0] FLAG_INIT   = 8'h9D;
  localparam logic [7:0] FLAG_ACTIVE = 8'h60;
  localparam logic       RST_SW_BOD_EN = 1'b1;

  // Event status and mask layout, one bit per reset cause.
  localparam int unsigned EVT_W         = 7;
  localparam int unsigned EVT_BROWNOUT  = 0;
  localparam int unsigned EVT_SOFT_RST  = 1;
  localparam int unsigned EVT_EXT_PIN   = 2;
  localparam int unsigned EVT_WATCHDOG  = 3;
  localparam int unsigned EVT_MEM_FAULT = 4;
  localparam int unsigned EVT_STK_OVER  = 5;
  localparam int unsigned EVT_STK_UNDER = 6;
  localparam logic [6:0]  RST_EVT       = 7'h00;

  typedef enum {SEL_NONE, SEL_BOD_CTRL, SEL_PRI, SEL_SEC, SEL_STATUS, SEL_MASK} rcf_sel_e;

  // Address decode shared by the read and write paths.
  function automatic rcf_sel_e rcf_decode(input logic [15:0] addr);
    rcf_sel_e sel;
    sel = SEL_NONE;
    if (addr == ADDR_BOD_CTRL) sel = SEL_BOD_CTRL;
    if (addr == ADDR_FLAGS_PRI) sel = SEL_PRI;
    if (addr == ADDR_FLAGS_SEC) sel = SEL_SEC;
    if (addr == ADDR_EVT_STATUS) sel = SEL_STATUS;
    if (addr == ADDR_EVT_MASK) sel = SEL_MASK;
    return sel;
  endfunction

endpackage

// File: hdl/rcf_flag_cell.sv
`timescale 1ns/1ps
module rcf_flag_cell
  import rcf_pkg::*;
#(
  parameter logic INIT   = 1'b1,
  parameter logic ACTIVE = 1'b0
)
(
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // Hardware update.
  input  wire logic init_i,
  input  wire logic cause_i,
  // Software write.
  input  wire logic wr_i,
  input  wire logic wdata_i,
  // Stored flag.
  output logic      flag_o
);

  // otherwise hold
  // Power-up and brown-out initialise, the own cause beats a write, else hold.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || init_i)
      flag_o <= INIT;
    else if (cause_i)
      flag_o <= ACTIVE;
    else if (wr_i)
      flag_o <= wdata_i;
  end

endmodule

// File: hdl/rcf_top.sv
// Notes on behaviour
// - Soft reset instruction clears soft reset flag.
// - Power-on or brown-out sets soft reset flag.
// - Power-on and brown-out clear power-on flag.
// - Power-on flag held otherwise; firmware may write.
// - Brown-out reset clears brownout flag.
// - Brownout flag held otherwise; firmware may write.
// - Memory violation clears mem fault flag.
// - Power-on or brown-out sets mem fault flag.
// - Only the actual cause's flag changes, except on a brown-out, which reloads all other flags.
// - Firmware writing active value makes no reset.
// - Watchdog reset clears flag; power events set.
// - Pin reset clears flag; power events set.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module rcf_top
  import rcf_pkg::*;
(
  // Clock and power-on reset.
  input  wire logic        CLK_I,
  input  wire logic        RST_B_I,
  // Software register port.
  input  wire logic [15:0] ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [7:0]  RDATA_O,
  // Reset-cause pulses from the reset controller.
  input  wire logic        BROWNOUT_RST_I,
  input  wire logic        SOFT_RST_I,
  input  wire logic        EXT_PIN_RST_I,
  input  wire logic        WATCHDOG_RST_I,
  input  wire logic        MEM_FAULT_RST_I,
  input  wire logic        STACK_OVER_I,
  input  wire logic        STACK_UNDER_I,
  // Brown-out circuit status and control.
  input  wire logic        BROWNOUT_READY_I,
  output logic             SW_BROWNOUT_EN_O,
  // Interrupt.
  output logic             IRQ_O
);

  rcf_sel_e               wr_sel;
  rcf_sel_e               rd_sel;
  logic                   wr_pri;
  logic                   wr_sec;
  logic                   wr_bod_ctrl;
  logic                   wr_status;
  logic                   wr_mask;
  logic [FLAG_N-1:0]      flag;
  logic [FLAG_N-1:0]      flag_cause;
  logic [FLAG_N-1:0]      flag_init;
  logic [FLAG_N-1:0]      flag_wr;
  logic [FLAG_N-1:0]      flag_wdata;
  logic [7:0]             pri_view;
  logic [7:0]             sec_view;
  logic [7:0]             bod_view;
  logic [7:0]             read_mux;
  logic [EVT_W-1:0]       evt_set;
  logic [EVT_W-1:0]       evt_status;
  logic [EVT_W-1:0]       evt_mask;
  logic [EVT_W-1:0]       next_evt_status;
  logic [EVT_W-1:0]       next_evt_mask;
  logic                   next_sw_bod_en;
  logic                   sw_bod_en;

  // Both decodes share one function so read and write maps cannot drift apart.
  assign wr_sel      = WR_I ? rcf_decode(ADDR_I) : SEL_NONE;
  assign rd_sel      = RD_I ? rcf_decode(ADDR_I) : SEL_NONE;
  assign wr_pri      = (wr_sel == SEL_PRI);
  assign wr_sec      = (wr_sel == SEL_SEC);
  assign wr_bod_ctrl = (wr_sel == SEL_BOD_CTRL);
  assign wr_status   = (wr_sel == SEL_STATUS);
  assign wr_mask     = (wr_sel == SEL_MASK);

  assign flag_cause[IDX_SOFT_RST]  = SOFT_RST_I;
  assign flag_cause[IDX_BROWNOUT]  = BROWNOUT_RST_I;
  assign flag_cause[IDX_MEM_FAULT] = MEM_FAULT_RST_I;
  assign flag_cause[IDX_WATCHDOG]  = WATCHDOG_RST_I;
  assign flag_cause[IDX_EXT_PIN]   = EXT_PIN_RST_I;
  // The power-on flag has no cause of its own; only initialisation or a firmware write clears it.
  assign flag_cause[IDX_POWER_ON]  = 1'b0;
  assign flag_cause[IDX_STK_OVER]  = STACK_OVER_I;
  assign flag_cause[IDX_STK_UNDER] = STACK_UNDER_I;

  // power flag, mem flag
  // A brown-out reloads every flag but its own, which its cause drives instead.
  always_comb
  begin
    flag_init               = {FLAG_N{BROWNOUT_RST_I}};
    flag_init[IDX_BROWNOUT] = 1'b0;
  end

  // Software write enables and data per cell.
  assign flag_wr[IDX_BROWNOUT]     = wr_pri;
  assign flag_wr[IDX_POWER_ON]     = wr_pri;
  assign flag_wr[IDX_SOFT_RST]     = wr_pri;
  assign flag_wr[IDX_EXT_PIN]      = wr_pri;
  assign flag_wr[IDX_WATCHDOG]     = wr_pri;
  assign flag_wr[IDX_STK_UNDER]    = wr_pri;
  assign flag_wr[IDX_STK_OVER]     = wr_pri;
  assign flag_wr[IDX_MEM_FAULT]    = wr_sec;
  assign flag_wdata[IDX_BROWNOUT]  = WDATA_I[BIT_BROWNOUT];
  assign flag_wdata[IDX_POWER_ON]  = WDATA_I[BIT_POWER_ON];
  assign flag_wdata[IDX_SOFT_RST]  = WDATA_I[BIT_SOFT_RST];
  assign flag_wdata[IDX_EXT_PIN]   = WDATA_I[BIT_EXT_PIN];
  assign flag_wdata[IDX_WATCHDOG]  = WDATA_I[BIT_WATCHDOG];
  assign flag_wdata[IDX_STK_UNDER] = WDATA_I[BIT_STACK_UNDER];
  assign flag_wdata[IDX_STK_OVER]  = WDATA_I[BIT_STACK_OVER];
  assign flag_wdata[IDX_MEM_FAULT] = WDATA_I[BIT_MEM_FAULT];

  // one cell per cause
  // Each cell's cause input is its own cause only; other flags move with a cause only on a brown-out, which reloads them.
  genvar gi;
  generate
    for (gi = 0; gi < FLAG_N; gi++)
    begin : g_flag
      rcf_flag_cell #(
        .INIT   (FLAG_INIT[gi]),
        .ACTIVE (FLAG_ACTIVE[gi])
      ) u_cell (
        .clk_i   (CLK_I),
        .rst_b_i (RST_B_I),
        .init_i  (flag_init[gi]),
        .cause_i (flag_cause[gi]),
        .wr_i    (flag_wr[gi]),
        .wdata_i (flag_wdata[gi]),
        .flag_o  (flag[gi])
      );
    end
  endgenerate

  // Register views; unused bits read as zero.
  always_comb
  begin
    pri_view                  = 8'h00;
    pri_view[BIT_BROWNOUT]    = flag[IDX_BROWNOUT];
    pri_view[BIT_POWER_ON]    = flag[IDX_POWER_ON];
    pri_view[BIT_SOFT_RST]    = flag[IDX_SOFT_RST];
    pri_view[BIT_EXT_PIN]     = flag[IDX_EXT_PIN];
    pri_view[BIT_WATCHDOG]    = flag[IDX_WATCHDOG];
    pri_view[BIT_STACK_UNDER] = flag[IDX_STK_UNDER];
    pri_view[BIT_STACK_OVER]  = flag[IDX_STK_OVER];
    sec_view                  = 8'h00;
    sec_view[BIT_MEM_FAULT]   = flag[IDX_MEM_FAULT];
    bod_view                  = 8'h00;
    bod_view[BIT_SW_BOD_EN]   = sw_bod_en;
    bod_view[BIT_BOD_READY]   = BROWNOUT_READY_I;
  end

  // Unmapped addresses read as zero.
  assign read_mux = (rd_sel == SEL_BOD_CTRL) ? bod_view :
                    (rd_sel == SEL_PRI)      ? pri_view :
                    (rd_sel == SEL_SEC)      ? sec_view :
                    (rd_sel == SEL_STATUS)   ? {1'b0, evt_status} :
                    (rd_sel == SEL_MASK)     ? {1'b0, evt_mask} : 8'h00;

  // writes only store
  // Flag writes reach the cells and nothing else: no cause pulse is raised.
  assign evt_set = {STACK_UNDER_I, STACK_OVER_I, MEM_FAULT_RST_I, WATCHDOG_RST_I,
                    EXT_PIN_RST_I, SOFT_RST_I, BROWNOUT_RST_I};

  // A set in the cycle of its write-one clear wins, so no event is lost.
  assign next_evt_status = (evt_status & ~(wr_status ? WDATA_I[EVT_W-1:0] : RST_EVT))
                           | evt_set;
  assign next_evt_mask   = wr_mask ? WDATA_I[EVT_W-1:0] : evt_mask;
  assign next_sw_bod_en  = BROWNOUT_RST_I ? RST_SW_BOD_EN :
                           wr_bod_ctrl ? WDATA_I[BIT_SW_BOD_EN] : sw_bod_en;

  // Status, mask and enable registers.
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      evt_status <= RST_EVT;
      evt_mask   <= RST_EVT;
      sw_bod_en  <= RST_SW_BOD_EN;
    end
    else
    begin
      evt_status <= next_evt_status;
      evt_mask   <= next_evt_mask;
      sw_bod_en  <= next_sw_bod_en;
    end
  end

  // Outputs come from flops; the interrupt is built from next values so it
  // tracks the status register with no extra cycle of lag.
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      RDATA_O          <= 8'h00;
      IRQ_O            <= 1'b0;
      SW_BROWNOUT_EN_O <= RST_SW_BOD_EN;
    end
    else
    begin
      RDATA_O          <= read_mux;
      IRQ_O            <= |(next_evt_status & next_evt_mask);
      SW_BROWNOUT_EN_O <= next_sw_bod_en;
    end
  end

  // Checks on the flag behaviour and the software port.
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  logic no_other_evt;
  assign no_other_evt = ~|evt_set;

  sequence s_wr_pri_quiet;
    wr_pri && no_other_evt;
  endsequence

  sequence s_rd_pri_quiet;
    (rd_sel == SEL_PRI) && no_other_evt && !WR_I;
  endsequence

  a_soft_flag_clear: assert property (SOFT_RST_I && !BROWNOUT_RST_I
                                      |=> !flag[IDX_SOFT_RST])
    else $error("soft reset flag not cleared");

  a_soft_flag_init: assert property (BROWNOUT_RST_I |=> flag[IDX_SOFT_RST])
    else $error("soft reset flag not set on brown-out");

  a_pwr_flag_clear: assert property (BROWNOUT_RST_I |=> !flag[IDX_POWER_ON])
    else $error("power-on flag not cleared by brown-out");

  a_pwr_flag_hold: assert property (!BROWNOUT_RST_I && !wr_pri
                                    |=> $stable(flag[IDX_POWER_ON]))
    else $error("power-on flag changed without cause");

  a_brownout_flag_clear: assert property (BROWNOUT_RST_I
                                          |=> !flag[IDX_BROWNOUT] && !pri_view[0])
    else $error("brownout flag not cleared");

  a_brownout_flag_write: assert property (!BROWNOUT_RST_I && wr_pri && WDATA_I[BIT_BROWNOUT]
                                          |=> flag[IDX_BROWNOUT])
    else $error("brownout flag write lost");

  a_mem_flag_clear: assert property (MEM_FAULT_RST_I && !BROWNOUT_RST_I
                                     |=> sec_view == 8'h00)
    else $error("mem fault flag not cleared");

  a_mem_flag_init: assert property (BROWNOUT_RST_I |=> flag[IDX_MEM_FAULT]
                                    && sec_view == 8'h02)
    else $error("mem fault flag not set on brown-out");

  a_other_flag_hold: assert property (SOFT_RST_I && !BROWNOUT_RST_I && !WATCHDOG_RST_I
                                      && !EXT_PIN_RST_I && !wr_pri
                                      |=> $stable(flag[IDX_EXT_PIN])
                                      && $stable(flag[IDX_WATCHDOG]))
    else $error("unrelated flag moved");

  a_write_no_cause: assert property (s_wr_pri_quiet |=> evt_status == $past(evt_status)
                                     || $past(wr_status))
    else $error("flag write raised a reset event");

  a_watchdog_flag_clear: assert property (WATCHDOG_RST_I && !BROWNOUT_RST_I
                                          |=> !flag[IDX_WATCHDOG])
    else $error("watchdog flag not cleared");

  a_pin_flag_init: assert property (BROWNOUT_RST_I |=> flag[IDX_EXT_PIN]
                                    && flag[IDX_WATCHDOG])
    else $error("pin or watchdog flag not set on brown-out");

  a_hw_over_write: assert property (SOFT_RST_I && wr_pri && WDATA_I[BIT_SOFT_RST]
                                    && !BROWNOUT_RST_I |=> !flag[IDX_SOFT_RST])
    else $error("firmware write beat hardware update");

  a_write_readback: assert property (s_wr_pri_quiet ##1 s_rd_pri_quiet
                                     |=> RDATA_O == ($past(WDATA_I, 2) & 8'hDF))
    else $error("primary flag read back mismatch");

  a_irq_level: assert property (##1 IRQ_O == |(evt_status & evt_mask))
    else $error("interrupt does not follow status and mask");

  // An unmasked event must raise the interrupt in the very next cycle.
  a_irq_on_event: assert property ((|(evt_set & evt_mask)) && !wr_mask |=> IRQ_O)
    else $error("unmasked event did not raise the interrupt");

  a_read_one_cycle: assert property (!RD_I |=> RDATA_O == 8'h00)
    else $error("read data outside answer cycle");

endmodule

// File: dv/test_rcf_top.sv
`timescale 1ns/1ps
module test_rcf_top
  import rcf_pkg::*;
;
  // Bench-side copies of the design ports; the inputs are driven from time zero.
  logic        clk   = 1'b0;
  logic        rst_b = 1'b0;
  logic [15:0] addr  = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        wr_s  = 1'b0;
  logic        rd_s  = 1'b0;
  logic        ready = 1'b1;
  logic [6:0]  cause = 7'h00;
  logic [7:0]  rdata;
  logic        sw_en;
  logic        irq;
  int          mismatches  = 0;
  int          checks_done = 0;
  // Flag values loaded before each cause and the values expected after it.
  logic [7:0]  pre_p [7] = '{8'h03, 8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'h1F};
  logic [7:0]  pre_s [7] = '{8'h00, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02};
  logic [7:0]  exp_p [7] = '{8'h1C, 8'h1B, 8'h17, 8'h0F, 8'h1F, 8'h9F, 8'h5F};
  logic [7:0]  exp_s [7] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h00, 8'h02, 8'h02};

  // A 50 ns period gives the 20 MHz system clock.
  always #25 clk = ~clk;

  rcf_top i_dut (
    .CLK_I            (clk),
    .RST_B_I          (rst_b),
    .ADDR_I           (addr),
    .WDATA_I          (wdata),
    .WR_I             (wr_s),
    .RD_I             (rd_s),
    .RDATA_O          (rdata),
    .BROWNOUT_RST_I   (cause[EVT_BROWNOUT]),
    .SOFT_RST_I       (cause[EVT_SOFT_RST]),
    .EXT_PIN_RST_I    (cause[EVT_EXT_PIN]),
    .WATCHDOG_RST_I   (cause[EVT_WATCHDOG]),
    .MEM_FAULT_RST_I  (cause[EVT_MEM_FAULT]),
    .STACK_OVER_I     (cause[EVT_STK_OVER]),
    .STACK_UNDER_I    (cause[EVT_STK_UNDER]),
    .BROWNOUT_READY_I (ready),
    .SW_BROWNOUT_EN_O (sw_en),
    .IRQ_O            (irq)
  );

  // Counts every comparison and reports a mismatch at once.
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One-cycle write strobe beside address and data.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(nm, rdata, exp);
  endtask

  // One-cycle pulse on one or more reset-cause inputs.
  task automatic pulse(input logic [6:0] c);
    @(posedge clk);
    cause <= c;
    @(posedge clk);
    cause <= 7'h00;
  endtask

  task automatic complete_run;
    $display("Counts: checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // A hung run is cut short and counted as a mismatch.
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("FAIL run_length expected finish seen limit");
    complete_run();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk("sw_en_reset", {7'h00, sw_en}, 8'h01);
    chk("irq_reset", {7'h00, irq}, 8'h00);
    rd(ADDR_FLAGS_PRI, 8'h1D, "pri_reset");
    rd(ADDR_FLAGS_SEC, 8'h02, "sec_reset");
    rd(ADDR_BOD_CTRL, 8'h81, "bod_ctrl_reset");
    rd(ADDR_EVT_STATUS, 8'h00, "status_reset");
    rd(ADDR_EVT_MASK, 8'h00, "mask_reset");
    rd(16'h0196, 8'h00, "unmapped_read");
    $display("test reset_values done");

    // Each cause alone, from known flag values; only its own flag may move, except a brown-out, which reloads all others.
    wr(ADDR_EVT_MASK, 8'h7F);
    for (int i = 0; i < 7; i++)
    begin
      wr(ADDR_FLAGS_PRI, pre_p[i]);
      wr(ADDR_FLAGS_SEC, pre_s[i]);
      wr(ADDR_BOD_CTRL, 8'h00);
      pulse(7'(7'h01 << i));
      rd(ADDR_FLAGS_PRI, exp_p[i], "pri_cause");
      rd(ADDR_FLAGS_SEC, exp_s[i], "sec_cause");
      rd(ADDR_EVT_STATUS, 8'(8'h01 << i), "status_cause");
      chk("irq_set", {7'h00, irq}, 8'h01);
      chk("sw_en_cause", {7'h00, sw_en}, (i == 0) ? 8'h01 : 8'h00);
      wr(ADDR_EVT_STATUS, 8'(8'h01 << i));
      rd(ADDR_EVT_STATUS, 8'h00, "status_clear");
      chk("irq_clear", {7'h00, irq}, 8'h00);
    end
    $display("test cause_table done");

    // A firmware write in the same cycle as a soft reset loses that bit.
    wr(ADDR_FLAGS_PRI, 8'h1F);
    @(posedge clk);
    addr  <= ADDR_FLAGS_PRI;
    wdata <= 8'h1F;
    wr_s  <= 1'b1;
    cause <= 7'h02;
    @(posedge clk);
    wr_s  <= 1'b0;
    cause <= 7'h00;
    rd(ADDR_FLAGS_PRI, 8'h1B, "pri_collide");
    wr(ADDR_EVT_STATUS, 8'h7F);
    $display("test write_collision done");

    // Active values written by firmware are stored but raise no event.
    wr(ADDR_FLAGS_PRI, 8'h00);
    wr(ADDR_FLAGS_SEC, 8'hFF);
    rd(ADDR_FLAGS_PRI, 8'h00, "pri_active_write");
    rd(ADDR_FLAGS_SEC, 8'h02, "sec_write_one");
    rd(ADDR_EVT_STATUS, 8'h00, "status_no_event");
    wr(ADDR_FLAGS_PRI, 8'hFF);
    rd(ADDR_FLAGS_PRI, 8'hDF, "pri_write_ones");
    wr(ADDR_FLAGS_SEC, 8'h00);
    rd(ADDR_FLAGS_SEC, 8'h00, "sec_active_write");
    $display("test firmware_writes done");

    // Back-to-back write then two reads, and read data standing one cycle.
    wr(ADDR_FLAGS_SEC, 8'h02);
    @(posedge clk);
    addr  <= ADDR_FLAGS_PRI;
    wdata <= 8'h0F;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
    rd_s  <= 1'b1;
    @(posedge clk);
    addr  <= ADDR_FLAGS_SEC;
    #1;
    chk("pri_b2b", rdata, 8'h0F);
    @(posedge clk);
    rd_s  <= 1'b0;
    #1;
    chk("sec_b2b", rdata, 8'h02);
    @(posedge clk);
    #1;
    chk("rdata_idle", rdata, 8'h00);
    wr(16'h0196, 8'hFF);
    rd(ADDR_FLAGS_PRI, 8'h0F, "pri_after_unmapped");
    $display("test bus_timing done");

    // Masked event sets status only; unmasking raises the interrupt.
    wr(ADDR_EVT_MASK, 8'h00);
    pulse(7'h08);
    rd(ADDR_EVT_STATUS, 8'h08, "status_masked");
    chk("irq_masked", {7'h00, irq}, 8'h00);
    rd(ADDR_FLAGS_PRI, 8'h0F, "pri_wdt_again");
    wr(ADDR_EVT_MASK, 8'h08);
    rd(ADDR_EVT_MASK, 8'h08, "mask_rw");
    chk("irq_unmasked", {7'h00, irq}, 8'h01);
    wr(ADDR_EVT_STATUS, 8'h08);
    rd(ADDR_EVT_STATUS, 8'h00, "status_w1c");
    chk("irq_w1c", {7'h00, irq}, 8'h00);
    $display("test interrupt_mask done");

    // Brown-out control: enable is stored, ready is read live.
    @(posedge clk);
    ready <= 1'b0;
    wr(ADDR_BOD_CTRL, 8'hFF);
    rd(ADDR_BOD_CTRL, 8'h80, "bod_ctrl_ones");
    chk("sw_en_set", {7'h00, sw_en}, 8'h01);
    @(posedge clk);
    ready <= 1'b1;
    wr(ADDR_BOD_CTRL, 8'h00);
    rd(ADDR_BOD_CTRL, 8'h01, "bod_ctrl_zero");
    chk("sw_en_clear", {7'h00, sw_en}, 8'h00);
    $display("test brownout_control done");
    complete_run();
  end
endmodule
